// ===== include/sfc_pkg.sv
// Shared constants and types for the serial flash fetch controller
package sfc_pkg;
  // ==========================================
  // Flash opcodes and fixed addresses
  localparam logic [7:0] FAST_READ_OP = 8'h0B;
  localparam logic [7:0] DUMMY_BYTE = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] OFF_DATA = 8'hFF;
  localparam logic [23:0] SIG_ADDR = 24'h00FFFA;
  localparam logic [31:0] SIG_WORD = 32'h32444655;
  localparam logic [23:0] CODE_START = 24'h000000;
  // ==========================================
  // Field positions and sizes
  localparam int IFACE_OFF_BIT = 0;
  localparam int LAUNCH_BIT = 0;
  localparam int DUAL_ADDR_BITS = 17;
  localparam logic [3:0] HDR_LAST = 4'h4;
  localparam logic [3:0] SIG_LAST = 4'h3;
  localparam logic [3:0] CMD_BYTES = 4'h8;
  localparam logic [5:0] CACHE_BYTES = 6'h20;
  localparam logic [3:0] BITS_SINGLE = 4'h8;
  localparam logic [3:0] BITS_DUAL = 4'h4;
  // ==========================================
  // Serial clock rates from the link clock
  localparam int LINK_PERIOD_PS = 15000;
  localparam int LINK_MHZ = 1000000 / LINK_PERIOD_PS;
  localparam int SLOW_MHZ = 30;
  localparam int FAST_MHZ = 60;
  // Half periods round up so the flash never sees a clock above its rate
  localparam int SLOW_HALF = (LINK_MHZ + 2 * SLOW_MHZ - 1) / (2 * SLOW_MHZ);
  localparam int FAST_HALF = (LINK_MHZ + 2 * FAST_MHZ - 1) / (2 * FAST_MHZ);
  localparam logic [1:0] SLOW_RELOAD = 2'(SLOW_HALF - 1);
  localparam logic [1:0] FAST_RELOAD = 2'(FAST_HALF - 1);
  // ==========================================
  // Types
  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_HDR, S_DATA, S_OPEN, S_HIT, S_CMD, S_END} sfc_state_t;
  typedef struct packed {
    logic [7:0] tx;
    logic dual;
    logic release_sel;
  } sfc_job_t;
endpackage

// ===== rtl/sfc_cache_mem.sv
// Byte memory holding the fetch cache, registered read
`timescale 1ns/1ps
module sfc_cache_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule

// ===== rtl/sfc_ctrl.sv
// Serial flash fetch controller: boot check, read streaming, cache, buffered commands
//
// Overview of operation
// - Check upgrade signature at 0xFFFA, enable external ROM
// - External ROM execution starts at address zero
// - Interface enabled at reset, software bit disables
// - Code read: select low, 0x0B, 24-bit address
// - Dummy byte, eight clocks per byte, then ready
// - Address plus one continues, cache hit keeps select low, else select high
// - Dual reads use programmed opcode, software loads 0x3B
// - Dual address: bits 23..17 zero, rest from bus
// - Dual data: four clocks, two bits each
// - 32-byte cache, base reloaded on every jump that misses
// - Sequential bytes fill cache, base slides past 32
// - Cache hit answers in one clock, no flash
// - Eight-byte command, response buffers and length
// - Launch bit: select low, eight clocks per byte
// - Bytes after opcode stored in response buffer
// - Bytes beyond command buffer send don't-care
// - Identification read returns three bytes, select high
// - Buffered path for commands, external data auto-read
// - Strap at reset selects 30 or 60 MHz; rounding from the link clock gives 16.7 or 33.3 MHz
`timescale 1ns/1ps
module sfc_ctrl (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic [7:0] utility_config_reg,
  input wire logic [7:0] fast_read_opcode_reg,
  input wire logic dual_mode_en,
  input wire logic [7:0] serial_control_reg,
  input wire logic [3:0] command_length,
  input wire logic [63:0] command_buffer,
  output logic [63:0] response_buffer,
  output logic launch_clear,
  output logic cmd_busy,
  input wire logic fetch_valid,
  input wire logic fetch_external_data_space,
  input wire logic [23:0] fetch_addr,
  output logic fetch_ready,
  output logic [7:0] fetch_data,
  output logic boot_done,
  output logic ext_rom_en,
  output logic [23:0] code_start_addr,
  input wire logic serial_rate_strap,
  output logic flash_sel_n,
  output logic flash_sck,
  output logic flash_serial_out,
  output logic flash_serial_out_en,
  input wire logic flash_serial_out_sense,
  input wire logic flash_serial_in
);
  // ==========================================
  // Core domain state
  sfc_pkg::sfc_state_t state_r, ret_r;
  sfc_pkg::sfc_job_t job_r, job_nxt;
  logic [3:0] idx_r;
  logic [23:0] addr_r, base_r, start_r;
  logic [5:0] len_r;
  logic [7:0] data_r;
  logic [63:0] resp_r;
  logic xd_r, dual_r, boot_r, cmd_r, first_r, sig_ok_r, wait_r, req_r, rdy_r, clr_r;
  logic ext_r, boot_done_r, ack_s1, ack_s2, ack_d, strap_s1, strap_s2, rate_r;
  // Link domain state
  sfc_pkg::sfc_job_t job_l;
  logic lrst_s1, lrst, req_s1, req_s2, req_d, rate_s1, rate_s2, si_s1, si_s2, so_s1, so_s2;
  logic busy_l, sck_l, cs_n_l, ack_l, dual_seen_l, rp1_l, rp2_l;
  logic [1:0] div_l;
  logic [3:0] rises_l, samp_l;
  logic [7:0] tx_l, rx_l, rx_hold_l;

  // ==========================================
  // Decode
  wire iface_off = utility_config_reg[sfc_pkg::IFACE_OFF_BIT];
  wire launch = serial_control_reg[sfc_pkg::LAUNCH_BIT];
  wire take = fetch_valid && !fetch_ready;
  wire use_dual = fetch_external_data_space && dual_mode_en;
  wire [23:0] eff = use_dual ? {7'h00, fetch_addr[16:0]} : fetch_addr;
  wire [23:0] off = eff - base_r;
  wire hit = (len_r != 6'h00) && (off < {18'h00000, len_r});
  wire seq = (eff == addr_r + 24'h000001) && (fetch_external_data_space == xd_r) && (use_dual == dual_r);
  wire ack_ev = ack_s2 ^ ack_d;
  wire st_idle = state_r == sfc_pkg::S_IDLE;
  wire st_hdr = state_r == sfc_pkg::S_HDR;
  wire st_data = state_r == sfc_pkg::S_DATA;
  wire st_cmd = state_r == sfc_pkg::S_CMD;
  wire st_end = state_r == sfc_pkg::S_END;
  wire st_open = state_r == sfc_pkg::S_OPEN;
  wire send = !wait_r && (st_hdr || st_data || st_cmd || st_end);
  wire [7:0] op = dual_r ? fast_read_opcode_reg : sfc_pkg::FAST_READ_OP;
  wire [7:0] hdr_byte = (idx_r == 4'h0) ? op :
                        (idx_r == 4'h1) ? addr_r[23:16] :
                        (idx_r == 4'h2) ? addr_r[15:8] :
                        (idx_r == 4'h3) ? addr_r[7:0] : sfc_pkg::DUMMY_BYTE;
  wire [7:0] cmd_byte = (idx_r < sfc_pkg::CMD_BYTES) ? command_buffer[8*idx_r[2:0] +: 8] :
                        sfc_pkg::FILL_BYTE;
  wire [7:0] sig_byte = sfc_pkg::SIG_WORD[8*(2'd3 - idx_r[1:0]) +: 8];
  wire [2:0] resp_idx = 3'(idx_r - 4'h1);
  wire resp_wr = st_cmd && ack_ev && (idx_r != 4'h0) && (idx_r <= sfc_pkg::CMD_BYTES);
  wire cache_wr = st_data && ack_ev && !boot_r;
  wire start_cmd = st_idle && !take && launch && boot_done_r;
  wire [7:0] hit_data;

  always_comb begin
    job_nxt.tx = st_hdr ? hdr_byte : st_cmd ? cmd_byte : sfc_pkg::DUMMY_BYTE;
    job_nxt.dual = st_data && dual_r;
    job_nxt.release_sel = st_end;
  end

  // ==========================================
  // Outputs
  assign fetch_ready = ce && (rdy_r || state_r == sfc_pkg::S_HIT);
  assign fetch_data = (state_r == sfc_pkg::S_HIT) ? hit_data : data_r;
  assign response_buffer = resp_r;
  assign launch_clear = clr_r;
  assign cmd_busy = cmd_r;
  assign boot_done = boot_done_r;
  assign ext_rom_en = ext_r;
  assign code_start_addr = start_r;
  assign flash_sel_n = cs_n_l;
  assign flash_sck = sck_l;
  assign flash_serial_out = tx_l[7];
  assign flash_serial_out_en = !cs_n_l && !dual_seen_l;

  // ==========================================
  // Strap and handshake synchronisers
  always_ff @(posedge mclk) begin
    strap_s1 <= serial_rate_strap;
    strap_s2 <= strap_s1;
    ack_s1 <= ack_l;
    ack_s2 <= ack_s1;
  end

  // Rate follows the strap while reset is held, then stays
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rate_r <= strap_s2;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_r <= 1'b0;
      wait_r <= 1'b0;
      job_r <= '0;
      ack_d <= 1'b0;
    end else if (ce) begin
      ack_d <= ack_s2;
      if (send) begin
        job_r <= job_nxt;
        req_r <= ~req_r;
        wait_r <= 1'b1;
      end else if (ack_ev) begin
        wait_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= sfc_pkg::S_BOOT;
      ret_r <= sfc_pkg::S_IDLE;
      idx_r <= 4'h0;
      addr_r <= 24'h000000;
      xd_r <= 1'b0;
      dual_r <= 1'b0;
      boot_r <= 1'b0;
      cmd_r <= 1'b0;
      first_r <= 1'b0;
      sig_ok_r <= 1'b0;
      rdy_r <= 1'b0;
      clr_r <= 1'b0;
      data_r <= 8'h00;
      ext_r <= 1'b0;
      boot_done_r <= 1'b0;
      start_r <= 24'h000000;
    end else if (ce) begin
      rdy_r <= 1'b0;
      clr_r <= 1'b0;
      case (state_r)
        sfc_pkg::S_BOOT: begin
          if (iface_off) begin
            boot_done_r <= 1'b1;
            state_r <= sfc_pkg::S_IDLE;
          end else begin
            addr_r <= sfc_pkg::SIG_ADDR;
            boot_r <= 1'b1;
            sig_ok_r <= 1'b1;
            idx_r <= 4'h0;
            state_r <= sfc_pkg::S_HDR;
          end
        end
        sfc_pkg::S_IDLE: begin
          if (take && iface_off) begin
            data_r <= sfc_pkg::OFF_DATA;
            rdy_r <= 1'b1;
          end else if (take && hit) begin
            ret_r <= sfc_pkg::S_IDLE;
            state_r <= sfc_pkg::S_HIT;
          end else if (take) begin
            addr_r <= eff;
            xd_r <= fetch_external_data_space;
            dual_r <= use_dual;
            first_r <= 1'b1;
            idx_r <= 4'h0;
            state_r <= sfc_pkg::S_HDR;
          end else if (start_cmd) begin
            clr_r <= 1'b1;
            idx_r <= 4'h0;
            // Disabled interface takes the launch but sends nothing
            if (command_length != 4'h0 && !iface_off) begin
              cmd_r <= 1'b1;
              state_r <= sfc_pkg::S_CMD;
            end
          end
        end
        sfc_pkg::S_HDR: begin
          if (ack_ev) begin
            idx_r <= (idx_r == sfc_pkg::HDR_LAST) ? 4'h0 : idx_r + 4'h1;
            if (idx_r == sfc_pkg::HDR_LAST) begin
              state_r <= sfc_pkg::S_DATA;
            end
          end
        end
        sfc_pkg::S_DATA: begin
          if (ack_ev && boot_r) begin
            sig_ok_r <= sig_ok_r && (rx_hold_l == sig_byte);
            idx_r <= idx_r + 4'h1;
            if (idx_r == sfc_pkg::SIG_LAST) begin
              state_r <= sfc_pkg::S_END;
            end
          end else if (ack_ev) begin
            data_r <= rx_hold_l;
            rdy_r <= 1'b1;
            first_r <= 1'b0;
            state_r <= sfc_pkg::S_OPEN;
          end
        end
        sfc_pkg::S_OPEN: begin
          if (take && seq && !iface_off) begin
            addr_r <= eff;
            state_r <= sfc_pkg::S_DATA;
          end else if (take && hit && !iface_off) begin
            ret_r <= sfc_pkg::S_OPEN;
            state_r <= sfc_pkg::S_HIT;
          end else if (take || launch || iface_off) begin
            state_r <= sfc_pkg::S_END;
          end
        end
        sfc_pkg::S_HIT: begin
          state_r <= ret_r;
        end
        sfc_pkg::S_CMD: begin
          if (ack_ev) begin
            idx_r <= idx_r + 4'h1;
            if (idx_r + 4'h1 == command_length) begin
              state_r <= sfc_pkg::S_END;
            end
          end
        end
        sfc_pkg::S_END: begin
          if (ack_ev) begin
            state_r <= sfc_pkg::S_IDLE;
            cmd_r <= 1'b0;
            boot_r <= 1'b0;
            if (boot_r) begin
              boot_done_r <= 1'b1;
              ext_r <= sig_ok_r;
              start_r <= sfc_pkg::CODE_START;
            end
          end
        end
        default: begin
          state_r <= sfc_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Response buffer and fetch cache
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      resp_r <= 64'h0000000000000000;
    end else if (ce && resp_wr) begin
      resp_r[8*resp_idx +: 8] <= rx_hold_l;
    end
  end

  // Commands may erase or program, so they drop the cache
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      base_r <= 24'h000000;
      len_r <= 6'h00;
    end else if (ce) begin
      if (start_cmd) begin
        len_r <= 6'h00;
      end else if (cache_wr && first_r) begin
        base_r <= addr_r;
        len_r <= 6'h01;
      end else if (cache_wr && len_r < sfc_pkg::CACHE_BYTES) begin
        len_r <= len_r + 6'h01;
      end else if (cache_wr) begin
        base_r <= base_r + 24'h000001;
      end
    end
  end

  sfc_cache_mem #(.DEPTH(32), .AW(5), .DW(8)) u_cache (
    .mclk(mclk),
    .ce(ce),
    .we(cache_wr),
    .waddr(addr_r[4:0]),
    .wdata(rx_hold_l),
    .raddr(eff[4:0]),
    .rdata(hit_data)
  );

  // ==========================================
  // Link domain: byte shifter on the link clock
  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst <= lrst_s1;
    req_s1 <= req_r;
    req_s2 <= req_s1;
    rate_s1 <= rate_r;
    rate_s2 <= rate_s1;
    si_s1 <= flash_serial_in;
    si_s2 <= si_s1;
    so_s1 <= flash_serial_out_sense;
    so_s2 <= so_s1;
  end

  wire [3:0] nbits = job_l.dual ? sfc_pkg::BITS_DUAL : sfc_pkg::BITS_SINGLE;
  wire tick = div_l == 2'h0;
  wire rise = busy_l && tick && !sck_l && (rises_l < nbits);
  wire done_l = busy_l && (rises_l == nbits) && !sck_l && (samp_l == nbits) && !rp1_l && !rp2_l;
  wire new_req = req_s2 ^ req_d;

  // Sample strobe trails the rise by the input synchroniser depth
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      div_l <= 2'h0;
      rp1_l <= 1'b0;
      rp2_l <= 1'b0;
    end else begin
      div_l <= tick ? (rate_s2 ? sfc_pkg::FAST_RELOAD : sfc_pkg::SLOW_RELOAD) : div_l - 2'h1;
      rp1_l <= rise;
      rp2_l <= rp1_l;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      req_d <= 1'b0;
      ack_l <= 1'b0;
      cs_n_l <= 1'b1;
      busy_l <= 1'b0;
      sck_l <= 1'b0;
      dual_seen_l <= 1'b0;
      job_l <= '0;
      rises_l <= 4'h0;
      samp_l <= 4'h0;
      tx_l <= 8'h00;
      rx_l <= 8'h00;
      rx_hold_l <= 8'h00;
    end else if (new_req && !busy_l) begin
      req_d <= req_s2;
      job_l <= job_r;
      if (job_r.release_sel) begin
        cs_n_l <= 1'b1;
        dual_seen_l <= 1'b0;
        ack_l <= ~ack_l;
      end else begin
        cs_n_l <= 1'b0;
        dual_seen_l <= dual_seen_l || job_r.dual;
        busy_l <= 1'b1;
        tx_l <= job_r.tx;
        rises_l <= 4'h0;
        samp_l <= 4'h0;
      end
    end else if (busy_l) begin
      if (rise) begin
        sck_l <= 1'b1;
        rises_l <= rises_l + 4'h1;
      end else if (tick && sck_l) begin
        sck_l <= 1'b0;
        tx_l <= {tx_l[6:0], 1'b1};
      end
      if (rp2_l) begin
        samp_l <= samp_l + 4'h1;
        rx_l <= job_l.dual ? {rx_l[5:0], si_s2, so_s2} : {rx_l[6:0], si_s2};
      end
      if (done_l) begin
        busy_l <= 1'b0;
        rx_hold_l <= rx_l;
        ack_l <= ~ack_l;
      end
    end
  end

  // ==========================================
  // Checks
  chk_hit_one_clock: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && (st_idle || st_open) && take && hit && !seq && !iface_off |=> fetch_ready)
    else $error("cache hit not answered next clock");
  chk_hit_no_flash: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == sfc_pkg::S_HIT |-> $stable(req_r))
    else $error("cache hit started a flash job");
  chk_off_stays_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && st_idle && iface_off |=> st_idle)
    else $error("disabled interface left idle");
  chk_dual_addr_mask: assert property (@(posedge mclk) disable iff (sys_rst)
    st_hdr && dual_r |-> addr_r[23:17] == 7'h00)
    else $error("dual address high bits not zero");
  chk_read_opcode: assert property (@(posedge mclk) disable iff (sys_rst)
    st_hdr && wait_r && idx_r == 4'h0 && !dual_r |-> job_r.tx == 8'h0B)
    else $error("wrong single read opcode");
  chk_dual_opcode: assert property (@(posedge mclk) disable iff (sys_rst)
    st_hdr && wait_r && idx_r == 4'h0 && dual_r |-> job_r.tx == fast_read_opcode_reg)
    else $error("dual read opcode not from register");
  chk_seq_continue: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && st_open && take && seq && !iface_off |=> st_data)
    else $error("sequential address did not continue");
  chk_jump_ends: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && st_open && take && !seq && !hit |=> st_end)
    else $error("jump did not end transfer");
  chk_cmd_filler: assert property (@(posedge mclk) disable iff (sys_rst)
    st_cmd && wait_r && idx_r >= 4'h8 |-> job_r.tx == 8'hFF)
    else $error("filler byte not driven past buffer");
  chk_cache_len: assert property (@(posedge mclk) disable iff (sys_rst)
    len_r <= 6'h20)
    else $error("cache length above 32");
  chk_launch_go: assert property (@(posedge mclk) disable iff (sys_rst)
    launch_clear && command_length != 4'h0 && !iface_off |-> st_cmd && cmd_busy)
    else $error("launch did not start command");
  chk_sel_clock: assert property (@(posedge link_clk) disable iff (lrst) cs_n_l |-> !sck_l)
    else $error("serial clock high with select released");

  cov_cache_hit: cover property (@(posedge mclk) state_r == sfc_pkg::S_HIT);
  cov_boot_ext: cover property (@(posedge mclk) boot_done_r && ext_r);
  cov_cmd_byte: cover property (@(posedge mclk) st_cmd && ack_ev && idx_r == 4'h3);
  cov_dual_byte: cover property (@(posedge mclk) st_data && dual_r && ack_ev);
endmodule

// ===== verif/sfc_flash_model.sv
// Behavioural serial flash answering the fetch controller
`timescale 1ns/1ps
module sfc_flash_model #(
  parameter logic [23:0] ID_BYTES = 24'h5A6B7C // Arbitrary identity value
) (
  input wire logic sig_ok,
  input wire logic flash_sel_n,
  input wire logic flash_sck,
  input wire logic flash_serial_out,
  output logic io0,
  output logic io0_en,
  output logic flash_serial_in,
  output logic [7:0] last_op,
  output logic [23:0] last_addr,
  output int nbits
);
  logic [31:0] sh;
  logic [7:0] b;
  int d;
  // ==========================================
  // Contents: upgrade signature when fitted, else an address hash
  function automatic logic [7:0] mem(input logic [23:0] x);
    logic [31:0] s;
    s = 32'h32444655;
    if (sig_ok && x >= 24'h00FFFA && x <= 24'h00FFFD) return s[8 * (24'h00FFFD - x) +: 8];
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5A;
  endfunction
  initial begin
    nbits = 0;
    io0 = 1'b0;
    io0_en = 1'b0;
    flash_serial_in = 1'b0;
    last_op = 8'h00;
    last_addr = 24'h000000;
  end
  // ==========================================
  // Shift in on the rising edge
  always @(negedge flash_sel_n) nbits = 0;
  always @(posedge flash_sck) begin
    if (!flash_sel_n) begin
      sh = {sh[30:0], flash_serial_out};
      nbits = nbits + 1;
      if (nbits == 8) last_op = sh[7:0];
      if (nbits == 32) last_addr = sh[23:0];
    end
  end
  // ==========================================
  // Answer on the falling edge; idle lines keep changing so no stale value passes
  always @(negedge flash_sck) begin
    if (!flash_sel_n) begin
      d = nbits - 40;
      if (last_op == 8'h3B && d >= 0) begin
        b = mem(last_addr + 24'(d / 4));
        io0_en = 1'b1;
        {flash_serial_in, io0} = b[2 * (3 - d % 4) +: 2];
      end else if (last_op == 8'h0B && d >= 0) begin
        b = mem(last_addr + 24'(d / 8));
        flash_serial_in = b[7 - d % 8];
      end else if (last_op == 8'h9F && nbits >= 8) begin
        flash_serial_in = ID_BYTES[23 - (nbits - 8) % 24];
      end else begin
        flash_serial_in = ~flash_serial_in;
        io0 = ~io0;
      end
    end
  end
  always @(posedge flash_sel_n) begin
    io0_en = 1'b0;
    io0 = ~io0;
    flash_serial_in = ~flash_serial_in;
  end
endmodule

// ===== verif/test_sfc_ctrl.sv
// Self-checking bench for the serial flash fetch controller
`timescale 1ns/1ps
module test_sfc_ctrl;
  localparam logic [23:0] ID = 24'hA1B2C3; // Arbitrary identity value
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] utility_config_reg = 8'h00;
  logic [7:0] fast_read_opcode_reg = 8'h3B;
  logic dual_mode_en = 1'b0;
  logic [7:0] serial_control_reg = 8'h00;
  logic [3:0] command_length = 4'h0;
  logic [63:0] command_buffer = 64'h0;
  logic fetch_valid = 1'b0;
  logic fetch_external_data_space = 1'b0;
  logic [23:0] fetch_addr = 24'h000000;
  logic serial_rate_strap = 1'b0;
  logic sig_ok = 1'b1;
  logic [63:0] response_buffer;
  logic launch_clear, cmd_busy, fetch_ready, boot_done, ext_rom_en, io0, io0_en;
  logic flash_sel_n, flash_sck, flash_serial_out, flash_serial_out_en, flash_serial_in;
  logic [7:0] fetch_data, last_op, got;
  logic [23:0] code_start_addr, last_addr, base;
  logic [7:0] ops [4] = '{8'h20, 8'h52, 8'hD8, 8'h02};
  logic [3:0] lens [4] = '{4'h4, 4'h4, 4'h4, 4'h5};
  int nbits, num_errors = 0, samples_checked = 0, cycles = 0, falls = 0, lat, f0, i, k;
  real t_rise = 0.0;
  real hi = 0.0;
  wire logic flash_serial_out_sense = flash_serial_out_en ? flash_serial_out : io0;
  always #4 mclk = ~mclk;
  initial begin
    #2.3;
    forever #7.5 link_clk = ~link_clk;
  end
  sfc_ctrl DUT (.mclk, .sys_rst, .ce, .link_clk, .utility_config_reg, .fast_read_opcode_reg, .dual_mode_en,
    .serial_control_reg, .command_length, .command_buffer, .response_buffer, .launch_clear, .cmd_busy,
    .fetch_valid, .fetch_external_data_space, .fetch_addr, .fetch_ready, .fetch_data, .boot_done, .ext_rom_en,
    .code_start_addr, .serial_rate_strap, .flash_sel_n, .flash_sck, .flash_serial_out, .flash_serial_out_en,
    .flash_serial_out_sense, .flash_serial_in);
  sfc_flash_model #(.ID_BYTES(ID)) flash (.sig_ok, .flash_sel_n, .flash_sck, .flash_serial_out, .io0,
    .io0_en, .flash_serial_in, .last_op, .last_addr, .nbits);
  // ==========================================
  // Monitors and hang guard
  always @(negedge flash_sel_n) falls++;
  always @(posedge flash_sck) t_rise = $realtime;
  always @(negedge flash_sck) hi = $realtime - t_rise;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ==========================================
  // Tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    @(negedge mclk);
    sys_rst = 1'b1;
    serial_rate_strap = strap;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    i = 0;
    while (boot_done !== 1'b1 && i < 5000) begin
      @(negedge mclk);
      i++;
    end
    check(boot_done, 1'b1);
    check(64'(int'(hi)), serial_rate_strap ? 64'h0F : 64'h1E);
  endtask
  // Request raised and left high after ready shows; release_fetch drops it
  task automatic fetch(input logic x, input logic [23:0] ad);
    @(negedge mclk);
    fetch_valid = 1'b1;
    fetch_external_data_space = x;
    fetch_addr = ad;
    lat = 0;
    do begin
      @(negedge mclk);
      lat++;
    end while (fetch_ready !== 1'b1 && lat < 3000);
    got = fetch_data;
    check(fetch_ready, 1'b1);
  endtask
  task automatic release_fetch();
    @(negedge mclk);
    fetch_valid = 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [3:0] len);
    @(negedge mclk);
    command_buffer = {$urandom, 24'($urandom), op};
    command_length = len;
    serial_control_reg = 8'h01;
    i = 0;
    do begin
      @(negedge mclk);
      i++;
    end while (launch_clear !== 1'b1 && i < 50);
    serial_control_reg = 8'h00;
    check(cmd_busy, 1'b1);
    while (cmd_busy !== 1'b0 && i < 5000) begin
      @(negedge mclk);
      i++;
    end
    check(cmd_busy, 1'b0);
    check(flash_sel_n, 1'b1);
    check(nbits, 32'(len) * 8);
    check(last_op, op);
    if (len >= 4) check(last_addr, {command_buffer[15:8], command_buffer[23:16], command_buffer[31:24]});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h6c133e99));
    do_reset(1'($urandom));
    check(ext_rom_en, 1'b1);
    check(code_start_addr, 24'h000000);
    base = 24'($urandom);
    f0 = falls;
    for (k = 0; k < 40; k++) begin
      fetch(1'b0, base + 24'(k));
      check(got, flash.mem(base + 24'(k)));
    end
    check(last_op, 8'h0B);
    check(last_addr, base);
    check(falls - f0, 32'h1);
    check(flash_serial_out_en, 1'b1);
    // Oldest byte still held after a 40-byte run, then the most recently evicted one
    fetch(1'b0, base + 24'h08);
    check(lat <= 2, 1'b1);
    check(got, flash.mem(base + 24'h08));
    check(falls - f0, 32'h1);
    fetch(1'b0, base + 24'h07);
    check(lat > 2, 1'b1);
    check(got, flash.mem(base + 24'h07));
    check(falls - f0, 32'h2);
    dual_mode_en = 1'b1;
    base = 24'($urandom) & 24'hFEFFFF;
    for (k = 0; k < 3; k++) begin
      fetch(1'b1, base + 24'(k));
      check(got, flash.mem({7'h00, 17'(base + 24'(k))}));
    end
    check(last_op, 8'h3B);
    check(last_addr, {7'h00, base[16:0]});
    check(flash_serial_out_en, 1'b0);
    release_fetch();
    dual_mode_en = 1'b0;
    cmd(8'h9F, 4'h4);
    check(response_buffer[23:0], {ID[7:0], ID[15:8], ID[23:16]});
    cmd(8'h9F, 4'hC);
    for (k = 0; k < 8; k++) check(response_buffer[8 * k +: 8], ID[23 - 8 * (k % 3) -: 8]);
    for (k = 0; k < 4; k++) cmd(ops[k], lens[k]);
    for (k = 0; k < 3; k++) cmd(8'($urandom), 4'h1);
    base = 24'($urandom);
    fetch(1'b1, base);
    check(got, flash.mem(base));
    check(last_op, 8'h0B);
    release_fetch();
    utility_config_reg = 8'h01;
    f0 = falls;
    fetch(1'b0, 24'($urandom));
    check(got, 8'hFF);
    check(falls - f0, 32'h0);
    release_fetch();
    sig_ok = 1'b0;
    utility_config_reg = 8'h00;
    do_reset(~serial_rate_strap);
    check(ext_rom_en, 1'b0);
    fetch(1'b0, 24'h00FFFA);
    check(got, flash.mem(24'h00FFFA));
    release_fetch();
    end_of_test();
  end
endmodule
